// *** src/mbc_regs.vh ***
`ifndef MBC_REGS_VH
`define MBC_REGS_VH
// Cycle kinds requested by the core side.
`define MBC_KIND_MEM_RD   3'h0
`define MBC_KIND_MEM_WR   3'h1
`define MBC_KIND_IO_RD    3'h2
`define MBC_KIND_IO_WR    3'h3
`define MBC_KIND_INTA     3'h4
// Status codes {io_mem, status_1, status_0}.
`define MBC_ST_MEM_WR     3'h1
`define MBC_ST_MEM_RD     3'h2
`define MBC_ST_IO_WR      3'h5
`define MBC_ST_IO_RD      3'h6
`define MBC_ST_INTA       3'h7
`define MBC_ST_HALT       2'h0
// Clock divide ratio of the processor clock.
`define MBC_CLK_DIV       2
`endif

// *** src/mbc_clkdiv.v ***
`timescale 1ns/1ns
`default_nettype none
module mbc_clkdiv (
	// Clock and reset
	input  wire clk,
	input  wire nrst,
	// Processor clock phase
	output reg  phase
);
	// Divide by two: every T state spans two edges of the input clock.
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			phase <= 1'b0;
		end else begin
			phase <= ~phase;
		end
	end
endmodule
`default_nettype wire

// *** src/mbc_bus_unit.v ***
// Contract
// - Upper address pins carry address high byte, or I/O port number.
// - Upper address, read and write strobes float in hold, halt, reset.
// - Low address byte drives the muxed bus in T1.
// - Muxed bus is data in T2 and T3; device drives only on writes.
// - Latch strobe pulses in T1, falls while address still valid.
// - Latch strobe is always driven, never floated.
// - Status: 001 mem write, 010 mem read, 110 I/O read, 111 ack; halt 00.
// - Status valid at cycle start and held through the whole cycle.
// - Read strobe low tells addressed party to drive read data.
// - Write strobe low while write data stands on the bus.
// - Ready low inserts whole wait states until sampled high.
// - Bus request honoured only after current transfer completes.
// - Bus not retaken until bus request is removed.
// - On acknowledge, address, data, strobes and io_mem float.
// - Halt with hold gives power-down, governed by bus request.
// - Address is sixteen bits from upper and lower bytes.
// - Ack rises, bus released next clock; retaken half clock after drop. Here the bus floats half a clock before ack rises.
// - Processor clock is the crystal input divided by two.
`timescale 1ns/1ns
`default_nettype none
`include "mbc_regs.vh"
module mbc_bus_unit (
	// Clock and reset
	input  wire        clk,
	input  wire        nrst,
	// Core request side
	input  wire        req_valid,
	input  wire [2:0]  req_kind,
	input  wire [15:0] req_addr,
	input  wire [7:0]  req_wdata,
	input  wire        halt_req,
	output reg         req_ready,
	output reg         rsp_valid,
	output reg  [7:0]  rsp_rdata,
	output reg         power_down,
	// Bus pins
	output reg  [7:0]  upper_address_byte,
	output reg         upper_address_oe,
	output reg  [7:0]  low_address_data_out,
	output reg         low_address_data_oe,
	input  wire [7:0]  low_address_data_in,
	output reg         ale,
	output reg         io_mem,
	output reg         io_mem_oe,
	output reg         cycle_status_1,
	output reg         cycle_status_0,
	output reg         rd_n,
	output reg         wr_n,
	output reg         strobe_oe,
	input  wire        ready,
	input  wire        bus_request,
	output reg         bus_surrender_ack,
	output reg         clk_out
);
	localparam S_IDLE = 3'h0;
	localparam S_T1   = 3'h1;
	localparam S_T2   = 3'h2;
	localparam S_TW   = 3'h3;
	localparam S_T3   = 3'h4;
	localparam S_HOLD = 3'h5;
	localparam S_HALT = 3'h6;

	wire       phase;
	reg  [1:0] ready_sync;
	reg  [1:0] hold_sync;
	reg  [7:0] data_sync0;
	reg  [7:0] data_sync1;
	reg  [2:0] state;
	reg  [2:0] next_state;
	reg  [2:0] kind;
	reg  [15:0] addr;
	reg  [7:0] wdata;
	reg        hold_seen;

	mbc_clkdiv u_div (
		.clk   (clk),
		.nrst  (nrst),
		.phase (phase)
	);

	function [2:0] status_code;
		input [2:0] k;
		begin
			case (k)
			`MBC_KIND_MEM_WR: status_code = `MBC_ST_MEM_WR;
			`MBC_KIND_IO_RD:  status_code = `MBC_ST_IO_RD;
			`MBC_KIND_IO_WR:  status_code = `MBC_ST_IO_WR;
			`MBC_KIND_INTA:   status_code = `MBC_ST_INTA;
			default:          status_code = `MBC_ST_MEM_RD;
			endcase
		end
	endfunction

	function is_write;
		input [2:0] k;
		begin
			is_write = (k == `MBC_KIND_MEM_WR) || (k == `MBC_KIND_IO_WR);
		end
	endfunction

	// Pin inputs come from outside and pass two flip-flops.
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			ready_sync <= 2'h0;
			hold_sync  <= 2'h0;
			data_sync0 <= 8'h00;
			data_sync1 <= 8'h00;
		end else begin
			ready_sync <= {ready_sync[0], ready};
			hold_sync  <= {hold_sync[0], bus_request};
			data_sync0 <= low_address_data_in;
			data_sync1 <= data_sync0;
		end
	end

	// One T state lasts one processor clock; state moves on phase high.
	always @* begin
		next_state = state;
		case (state)
		S_IDLE: begin
			if (hold_sync[1]) begin
				next_state = S_HOLD;
			end else if (req_valid) begin
				next_state = S_T1;
			end else if (halt_req) begin
				next_state = S_HALT;
			end
		end
		S_T1: begin
			next_state = S_T2;
		end
		S_T2: begin
			if (ready_sync[1]) begin
				next_state = S_T3;
			end else begin
				next_state = S_TW;
			end
		end
		S_TW: begin
			if (ready_sync[1]) begin
				next_state = S_T3;
			end
		end
		S_T3: begin
			next_state = S_IDLE;
		end
		S_HOLD: begin
			if (!hold_sync[1]) begin
				next_state = S_IDLE;
			end
		end
		S_HALT: begin
			if (hold_sync[1]) begin
				next_state = S_HOLD;
			end else if (!halt_req) begin
				next_state = S_IDLE;
			end
		end
		default: begin
			next_state = S_IDLE;
		end
		endcase
	end

	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			state     <= S_IDLE;
			kind      <= 3'h0;
			addr      <= 16'h0000;
			wdata     <= 8'h00;
			hold_seen <= 1'b0;
		end else if (phase) begin
			state <= next_state;
			if (state == S_IDLE && next_state == S_T1) begin
				kind  <= req_kind;
				addr  <= req_addr;
				wdata <= req_wdata;
			end
			hold_seen <= (next_state == S_HOLD);
		end
	end

	// All pin outputs are registered; all but ack and clk_out update on the T-state edge.
	always @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			upper_address_byte   <= 8'h00;
			upper_address_oe     <= 1'b0;
			low_address_data_out <= 8'h00;
			low_address_data_oe  <= 1'b0;
			ale                  <= 1'b0;
			io_mem               <= 1'b0;
			io_mem_oe            <= 1'b0;
			cycle_status_1       <= 1'b0;
			cycle_status_0       <= 1'b0;
			rd_n                 <= 1'b1;
			wr_n                 <= 1'b1;
			strobe_oe            <= 1'b0;
			bus_surrender_ack    <= 1'b0;
			power_down           <= 1'b0;
			req_ready            <= 1'b0;
			rsp_valid            <= 1'b0;
			rsp_rdata            <= 8'h00;
			clk_out              <= 1'b0;
		end else begin
			// Mirrors the divider, so the pin toggles on every rising input edge.
			clk_out   <= ~phase;
			req_ready <= 1'b0;
			rsp_valid <= 1'b0;
			if (phase) begin
				// Latch strobe falls at the end of T1, address still out.
				ale <= (next_state == S_T1);
				case (next_state)
				S_T1: begin
					req_ready            <= 1'b1;
					upper_address_byte   <= req_addr[15:8];
					upper_address_oe     <= 1'b1;
					low_address_data_out <= req_addr[7:0];
					low_address_data_oe  <= 1'b1;
					{io_mem, cycle_status_1, cycle_status_0}
						<= status_code(req_kind);
					io_mem_oe            <= 1'b1;
					strobe_oe            <= 1'b1;
					rd_n                 <= 1'b1;
					wr_n                 <= 1'b1;
				end
				S_T2, S_TW, S_T3: begin
					// Status pins keep their T1 value.
					low_address_data_out <= wdata;
					low_address_data_oe  <= is_write(kind);
					rd_n                 <= is_write(kind);
					wr_n                 <= ~is_write(kind);
				end
				S_HOLD: begin
					upper_address_oe    <= 1'b0;
					low_address_data_oe <= 1'b0;
					io_mem_oe           <= 1'b0;
					strobe_oe           <= 1'b0;
					rd_n                <= 1'b1;
					wr_n                <= 1'b1;
				end
				S_HALT: begin
					upper_address_oe    <= 1'b0;
					low_address_data_oe <= 1'b0;
					io_mem_oe           <= 1'b0;
					cycle_status_1      <= 1'b0;
					cycle_status_0      <= 1'b0;
					strobe_oe           <= 1'b0;
					rd_n                <= 1'b1;
					wr_n                <= 1'b1;
				end
				default: begin
					// Idle: strobes parked high, upper address enable keeps its previous value.
					low_address_data_oe <= 1'b0;
					rd_n                <= 1'b1;
					wr_n                <= 1'b1;
				end
				endcase
				if (state == S_T3) begin
					rsp_valid <= 1'b1;
					rsp_rdata <= data_sync1;
				end
				// Power-down holds while halted and the bus is surrendered.
				power_down <= (next_state == S_HOLD) && halt_req;
			end else begin
				// Ack raised mid T state, half a clock after the bus floated.
				// Ack drops here; bus retaken half a clock later if a request waits, else at the next T1.
				bus_surrender_ack <= hold_seen;
			end
		end
	end
endmodule
`default_nettype wire

// *** bench/mbc_bus_unit_chk.sv ***
`timescale 1ns/1ns
`default_nettype none
module mbc_bus_unit_chk (
	// Clock and reset
	input wire logic clk, nrst,
	// Bus pins
	input wire logic ale, rd_n, wr_n, strobe_oe, io_mem, io_mem_oe,
	input wire logic cycle_status_1, cycle_status_0,
	input wire logic upper_address_oe, low_address_data_oe,
	input wire logic bus_request, bus_surrender_ack, clk_out
);
	default clocking @(posedge clk); endclocking
	default disable iff (!nrst);
	a_ale_addr_out: assert property (ale |-> low_address_data_oe && upper_address_oe)
		else $error("ale without address");
	a_rd_wr_excl: assert property (strobe_oe |-> rd_n || wr_n)
		else $error("both strobes low");
	a_wr_data: assert property (strobe_oe && !wr_n |-> low_address_data_oe)
		else $error("write strobe without data");
	a_rd_float: assert property (strobe_oe && !rd_n |-> !low_address_data_oe)
		else $error("bus driven on read");
	a_hold_float: assert property (bus_surrender_ack |->
		!(upper_address_oe || strobe_oe || io_mem_oe || low_address_data_oe || ale))
		else $error("bus driven in hold");
	a_status_hold: assert property (strobe_oe && !rd_n && $past(!rd_n) |->
		$stable({io_mem, cycle_status_1, cycle_status_0}))
		else $error("status moved in cycle");
	a_wr_code: assert property (strobe_oe && !wr_n |-> !cycle_status_1 && cycle_status_0)
		else $error("bad write status");
	a_rd_code: assert property (strobe_oe && !rd_n |-> cycle_status_1)
		else $error("bad read status");
	a_ack_drop: assert property (!bus_request [*8] |-> !bus_surrender_ack)
		else $error("ack kept without request");
	a_clk_div: assert property ($past(nrst) |-> clk_out != $past(clk_out))
		else $error("clock output not halved");
	c_read: cover property (strobe_oe && !rd_n);
	c_write: cover property (strobe_oe && !wr_n);
	c_hold: cover property ($rose(bus_surrender_ack));
endmodule
bind mbc_bus_unit mbc_bus_unit_chk u_chk (.clk, .nrst, .ale, .rd_n, .wr_n,
	.strobe_oe, .io_mem, .io_mem_oe, .cycle_status_1, .cycle_status_0,
	.upper_address_oe, .low_address_data_oe, .bus_request,
	.bus_surrender_ack, .clk_out);
`default_nettype wire

// *** bench/mbc_mem_model.sv ***
`timescale 1ns/1ns
`default_nettype none
// Memory and I/O party; an idle bus shows a pattern that flips every cycle.
module mbc_mem_model (
	input  wire logic        clk,
	input  wire logic        ale,
	input  wire logic        rd_n,
	input  wire logic        wr_n,
	input  wire logic [7:0]  ua,
	input  wire logic [7:0]  bus,
	input  wire logic [3:0]  waits,
	output logic      [7:0]  dout,
	output logic             rdy,
	output logic      [15:0] addr,
	output logic      [7:0]  wdata
);
	logic [4:0] cnt = 5'h00;
	initial dout = 8'h00;
	assign rdy = cnt == 5'h00;
	always @(posedge clk) begin
		cnt <= ale ? {waits, 1'b0} : cnt - {4'h0, cnt != 5'h00};
		dout <= rd_n ? ~dout : addr[7:0] ^ addr[15:8];
		if (ale)
			addr <= {ua, bus};
		if (!wr_n)
			wdata <= bus;
	end
endmodule
`default_nettype wire

// *** bench/mbc_bus_unit_tb.sv ***
`timescale 1ns/1ns
`default_nettype none
`include "mbc_regs.vh"
module mbc_bus_unit_tb;
	logic        clk = 1'b0;
	logic        nrst = 1'b0;
	logic        req_valid = 1'b0;
	logic        halt_req = 1'b0;
	logic        bus_request = 1'b0;
	logic [2:0]  kind = 3'h0;
	logic [15:0] addr = 16'h0000;
	logic [7:0]  wdat = 8'h00;
	logic [3:0]  waits = 4'h0;
	integer      n_fail = 0;
	integer      check_count = 0;
	integer      ticks = 0;
	integer      lat;
	integer      lat0;
	wire  [7:0]  ua, dout, din, rdata, w_m;
	wire  [15:0] a_m;
	wire         req_ready, rsp_valid, pd, ua_oe, d_oe, ale, iom, iom_oe;
	wire         s1, s0, rd_n, wr_n, s_oe, rdy, ack;
	wire         rd = s_oe ? rd_n : 1'b1;
	wire         wr = s_oe ? wr_n : 1'b1;
	wire  [7:0]  bus = d_oe ? dout : din;
	mbc_bus_unit u_dut (.clk(clk), .nrst(nrst), .req_valid(req_valid),
		.req_kind(kind), .req_addr(addr), .req_wdata(wdat),
		.halt_req(halt_req), .req_ready(req_ready), .rsp_valid(rsp_valid),
		.rsp_rdata(rdata), .power_down(pd), .upper_address_byte(ua),
		.upper_address_oe(ua_oe), .low_address_data_out(dout),
		.low_address_data_oe(d_oe), .low_address_data_in(bus), .ale(ale),
		.io_mem(iom), .io_mem_oe(iom_oe), .cycle_status_1(s1),
		.cycle_status_0(s0), .rd_n(rd_n), .wr_n(wr_n), .strobe_oe(s_oe),
		.ready(rdy), .bus_request(bus_request), .bus_surrender_ack(ack),
		.clk_out());
	mbc_mem_model u_mem (.clk(clk), .ale(ale), .rd_n(rd), .wr_n(wr),
		.ua(ua), .bus(bus), .waits(waits), .dout(din), .rdy(rdy),
		.addr(a_m), .wdata(w_m));
	initial forever #5 clk = ~clk;
	task automatic chk(input [15:0] got, input [15:0] exp);
		check_count++;
		if (got !== exp) begin
			n_fail++;
			$display("Error at %0t: got %h exp %h", $time, got, exp);
		end
	endtask
	task automatic stop_test;
		$display("Checks %0d, mismatches %0d", check_count, n_fail);
		if (n_fail == 0 && check_count > 0)
			$display("Testbench passed");
		else
			$display("Testbench failed");
		$finish;
	endtask
	task automatic cyc(input [2:0] k, input [15:0] a, input [7:0] d,
		input [3:0] w, input [2:0] st);
		integer n;
		@(posedge clk) #1;
		{req_valid, kind, addr, wdat, waits} = {1'b1, k, a, d, w};
		for (n = 0; n < 60 && !req_ready; n++) @(posedge clk) #1;
		req_valid = 1'b0;
		for (n = 0; n < 60 && rd && wr; n++) @(posedge clk) #1;
		chk({iom, s1, s0}, st);
		chk(a_m, a);
		for (lat = 0; lat < 60 && !rsp_valid; lat++) @(posedge clk) #1;
		if (k == `MBC_KIND_MEM_WR || k == `MBC_KIND_IO_WR)
			chk(w_m, d);
		else
			chk(rdata, a[7:0] ^ a[15:8]);
	endtask
	task automatic t_hold;
		integer n;
		bus_request = 1'b1;
		for (n = 0; n < 40 && !ack; n++) @(posedge clk) #1;
		chk({ua_oe, d_oe, s_oe, iom_oe, ack}, 5'h01);
		{req_valid, halt_req} = 2'h3;
		repeat (10) @(posedge clk) #1;
		chk({pd, ale}, 2'h2);
		{req_valid, halt_req, bus_request} = 3'h0;
		for (n = 0; n < 40 && ack; n++) @(posedge clk) #1;
		chk(ack, 1'b0);
	endtask
	task automatic t_halt;
		halt_req = 1'b1;
		repeat (8) @(posedge clk) #1;
		chk({iom_oe, s1, s0, ua_oe, s_oe, ale}, 6'h00);
		halt_req = 1'b0;
	endtask
	task automatic t_reset;
		nrst = 1'b0;
		#1 chk({ua_oe, d_oe, s_oe, ale}, 4'h0);
		@(posedge clk) #1 nrst = 1'b1;
	endtask
	always @(posedge clk) begin
		ticks++;
		if (ticks == 20000) begin
			n_fail++;
			stop_test;
		end
	end
	initial begin
		repeat (2) @(posedge clk);
		#1 nrst = 1'b1;
		cyc(`MBC_KIND_MEM_RD, 16'hA53C, 8'h00, 4'h0, 3'h2);
		lat0 = lat;
		cyc(`MBC_KIND_MEM_WR, 16'h12FE, 8'h5A, 4'h0, 3'h1);
		cyc(`MBC_KIND_IO_RD, 16'h4545, 8'h00, 4'h0, 3'h6);
		cyc(`MBC_KIND_IO_WR, 16'h8181, 8'hC3, 4'h2, 3'h5);
		cyc(`MBC_KIND_INTA, 16'h0FF0, 8'h00, 4'h0, 3'h7);
		cyc(`MBC_KIND_MEM_RD, 16'hFFFF, 8'h00, 4'h3, 3'h2);
		chk(lat > lat0 + 1, 1'b1);
		t_hold;
		cyc(`MBC_KIND_MEM_WR, 16'h0000, 8'hFF, 4'h0, 3'h1);
		t_halt;
		t_reset;
		cyc(`MBC_KIND_MEM_RD, 16'h7E81, 8'h00, 4'h1, 3'h2);
		stop_test;
	end
endmodule
`default_nettype wire
